// File: src/eeprom_ctl_pkg.sv
// Summary of operation
// R1: Latch only valid EEPROM writes while latching.
// R2: Newer valid write replaces latched address, data.
// R3: Block erase clears whole block of target.
// R4: Bulk erase clears entire array.
// R5: Block and bulk never touch config byte.
// R6: Latching reads return latched data.
// R7: While latching, control writes refused until valid write latched.
// R8: Voltage enable needs latch and valid write.
// R9: Erase mode frozen while voltage enabled.
// R10: Voltage enable drives pump and array voltage.
// R11: Clearing both bits clears voltage only.
// R12: Four 128-byte blocks, guard bit each.
// R13: Guarded target block gets no voltage.
// R14: Guard changes act after reset or read.
// R15: Config byte copied at reset, each read.
// R16: Secure zone blocks program and erase.
// R17: Secure option disables block and bulk.
// R18: Secure option freezes config byte writes.
// R19: Unsecured bytes still accept byte erase.
// R20: Secure zone reads return stored data.
// R21: Secure zone writes are not valid writes.
// R22: Secure option stays armed for good.
// R23: Mode codes 00,01,10,11; guard overrides.
// R24: Latch cannot clear while voltage enabled.
// R25: Software drops voltage, waits, then unlatches.
package eeprom_ctl_pkg;

    // Bus widths of the CPU side.
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;

    // Array placement and block geometry.
    localparam logic [15:0] ARRAY_BASE  = 16'h0800;
    localparam logic [15:0] ARRAY_LAST  = 16'h09FF;
    localparam int unsigned BLOCK_SHIFT = 7;
    localparam int unsigned NUM_BLOCKS  = 4;
    localparam int unsigned BLOCK_IDX_W = 2;

    // Range closed off by the secure option.
    localparam logic [15:0] SECURE_LO = 16'h08F0;
    localparam logic [15:0] SECURE_HI = 16'h08FF;

    // Address of the nonvolatile configuration byte.
    localparam logic [15:0] NV_ADDR = 16'hFE18;

    // Field positions in the array control register write data.
    localparam int unsigned CTL_HV_BIT     = 0;
    localparam int unsigned CTL_LATCH_BIT  = 2;
    localparam int unsigned CTL_ERS_LO_BIT = 3;
    localparam int unsigned CTL_ERS_HI_BIT = 4;

    // Field positions in the configuration byte.
    localparam int unsigned CFG_GUARD_LSB  = 0;
    localparam int unsigned CFG_SECURE_BIT = 4;

    // Volatile configuration before the first copy: all guarded, not secure.
    localparam logic [7:0] CFG_RESET = 8'h7F;

    // Program and erase mode codes.
    typedef enum logic [1:0] {
        MODE_BYTE_PGM    = 2'b00,
        MODE_BYTE_ERASE  = 2'b01,
        MODE_BLOCK_ERASE = 2'b10,
        MODE_BULK_ERASE  = 2'b11
    } erase_mode_t;

endpackage

// File: src/eeprom_guard_check.sv
`timescale 1ns/1ps
// Decides whether a latched target may receive program or erase voltage.
module eeprom_guard_check (
    // Target of the pending operation.
    input  wire logic [15:0] targetAddr,
    input  wire logic [1:0]  modeSel,
    // Active configuration.
    input  wire logic [7:0]  cfgByte,
    input  wire logic        secureArmed,
    // Verdict.
    output logic             blocked,
    output logic [1:0]       blockIdx
);

    logic [15:0] offset;   // Distance from the array base.
    logic        inArray;  // Target is an array byte.
    logic        isNv;     // Target is the configuration byte.
    logic        inZone;   // Target is in the secured range.
    logic        guardHit; // Guard bit of the target block is set.
    logic        anyGuard; // Some block is guarded.
    logic        wideMode; // Block or bulk erase selected.

    // Pure decode; every term is recomputed from the inputs each cycle.
    always_comb begin
        offset   = targetAddr - eeprom_ctl_pkg::ARRAY_BASE;
        blockIdx = offset[eeprom_ctl_pkg::BLOCK_SHIFT +: eeprom_ctl_pkg::BLOCK_IDX_W]; // see R12
        inArray  = (targetAddr >= eeprom_ctl_pkg::ARRAY_BASE) && (targetAddr <= eeprom_ctl_pkg::ARRAY_LAST);
        isNv     = (targetAddr == eeprom_ctl_pkg::NV_ADDR);
        inZone   = (targetAddr >= eeprom_ctl_pkg::SECURE_LO) && (targetAddr <= eeprom_ctl_pkg::SECURE_HI);
        guardHit = cfgByte[eeprom_ctl_pkg::CFG_GUARD_LSB + int'(blockIdx)];
        anyGuard = |cfgByte[eeprom_ctl_pkg::CFG_GUARD_LSB +: eeprom_ctl_pkg::NUM_BLOCKS];
        wideMode = (modeSel == eeprom_ctl_pkg::MODE_BLOCK_ERASE) || (modeSel == eeprom_ctl_pkg::MODE_BULK_ERASE);
        blocked  = 1'b0;
        // Nothing outside the array and the configuration byte is ever a target.
        if (!inArray && !isNv) begin
            blocked = 1'b1;
        end
        // A guarded block overrides every mode.
        if (inArray && guardHit) begin
            blocked = 1'b1; // see R13 see R23
        end
        // Bulk erase does not apply while any block is guarded.
        if ((modeSel == eeprom_ctl_pkg::MODE_BULK_ERASE) && anyGuard) begin
            blocked = 1'b1; // see R4
        end
        // Block and bulk erase have no meaning for the configuration byte.
        if (isNv && wideMode) begin
            blocked = 1'b1; // see R5
        end
        // The secure option closes the zone, the wide modes and the byte.
        if (secureArmed && (inZone || wideMode || isNv)) begin
            blocked = 1'b1; // see R16 see R17 see R18
        end
    end

endmodule // eeprom_guard_check

// File: src/eeprom_erase_protect_control.sv
`timescale 1ns/1ps
// Erase, latch and protection control for one 512-byte EEPROM array.
// The array macro itself sits outside; this block tells it what to do
// and when voltage may be applied.
module eeprom_erase_protect_control (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // CPU accesses aimed at the array or the configuration byte.
    input  wire logic [15:0] busAddr,
    input  wire logic [7:0]  busWrData,
    input  wire logic        busWr,
    input  wire logic        busRd,
    // CPU writes to the array control register.
    input  wire logic        ctrlWr,
    input  wire logic [7:0]  ctrlWrData,
    // Contents coming back from the array macro.
    input  wire logic [7:0]  arrayRdData,
    input  wire logic [7:0]  nvStoredByte,
    // Read answer to the CPU.
    output logic [7:0]       rdData,
    // Array control register state.
    output logic             latchEnable,
    output logic             hvApply,
    output logic [1:0]       eraseSelect,
    output logic             ctrlRefused,
    // Latched target for the array macro.
    output logic             latchValid,
    output logic [15:0]      latchedAddr,
    output logic [7:0]       latchedData,
    output logic [1:0]       opBlock,
    // Charge pump and array voltage.
    output logic             pumpOn,
    // Active configuration.
    output logic [7:0]       volatileConfig,
    output logic             secureArmed
);

    // All state of the block in one record.
    typedef struct packed {
        logic        latchEn;     // Buses configured for latching.
        logic        hv;          // Voltage enable bit as software sees it.
        logic [1:0]  ersSel;      // Erase select, high then low bit.
        logic        ctrlRef;     // Control write in the previous cycle was refused.
        logic        latValid;    // A valid write has been latched.
        logic [15:0] latAddr;     // Latched address.
        logic [7:0]  latData;     // Latched data.
        logic [1:0]  opBlk;       // Block index of the latched address.
        logic        pump;        // Pump running and voltage on array.
        logic [7:0]  rdData;      // Last read answer.
        logic [7:0]  cfg;         // Volatile configuration copy.
        logic        cfgLoadPend; // Copy from the stored byte is due.
        logic        secure;      // Secure option seen armed.
    } state_t;

    // Reset record; the configuration copy follows on the first edge.
    localparam state_t S_RESET = '{
        latchEn:     1'b0,
        hv:          1'b0,
        ersSel:      2'b00,
        ctrlRef:     1'b0,
        latValid:    1'b0,
        latAddr:     16'h0000,
        latData:     8'h00,
        opBlk:       2'b00,
        pump:        1'b0,
        rdData:      8'h00,
        cfg:         eeprom_ctl_pkg::CFG_RESET,
        cfgLoadPend: 1'b1,
        secure:      1'b0
    };

    state_t      s_q;        // Registered state.
    state_t      s_d;        // Next state.
    logic        wrValid;    // Current bus write qualifies for latching.
    logic        guardBlk;   // Next target may not receive voltage.
    logic [1:0]  guardIdx;   // Block index of the next target.
    logic        wantHv;     // Control write asks for voltage.
    logic        wantLatch;  // Control write asks for latching.
    logic [1:0]  wantErs;    // Control write asks for this erase mode.

    // True for an address inside the array.
    function automatic logic isArrayAddr(input logic [15:0] a);
        return (a >= eeprom_ctl_pkg::ARRAY_BASE) && (a <= eeprom_ctl_pkg::ARRAY_LAST);
    endfunction

    // True for an address inside the secured range.
    function automatic logic isZoneAddr(input logic [15:0] a);
        return (a >= eeprom_ctl_pkg::SECURE_LO) && (a <= eeprom_ctl_pkg::SECURE_HI);
    endfunction

    // True for the address of the configuration byte.
    function automatic logic isNvAddr(input logic [15:0] a);
        return (a == eeprom_ctl_pkg::NV_ADDR);
    endfunction

    // The guard judges the target as it will stand after this edge, so
    // the registered pump bit never lags the latched address by a cycle.
    eeprom_guard_check u_guard (
        .targetAddr  (s_d.latAddr),
        .modeSel     (s_d.ersSel),
        .cfgByte     (s_d.cfg),
        .secureArmed (s_d.secure),
        .blocked     (guardBlk),
        .blockIdx    (guardIdx)
    );

    // Split the control write data into its fields.
    always_comb begin
        wantHv    = ctrlWrData[eeprom_ctl_pkg::CTL_HV_BIT];
        wantLatch = ctrlWrData[eeprom_ctl_pkg::CTL_LATCH_BIT];
        wantErs   = {ctrlWrData[eeprom_ctl_pkg::CTL_ERS_HI_BIT],
                     ctrlWrData[eeprom_ctl_pkg::CTL_ERS_LO_BIT]};
    end

    // A write is valid when it hits the array or the configuration byte,
    // except where the armed secure option has closed that location.
    always_comb begin
        wrValid = busWr && (isArrayAddr(busAddr) || isNvAddr(busAddr)); // see R1
        if (s_q.secure && (isZoneAddr(busAddr) || isNvAddr(busAddr))) begin
            wrValid = 1'b0; // see R21 see R18
        end
    end

    // Next-state logic for the whole block.
    always_comb begin
        s_d         = s_q;
        s_d.ctrlRef = 1'b0;

        // First edge after reset: take the stored configuration byte.
        if (s_q.cfgLoadPend) begin
            s_d.cfg         = nvStoredByte; // see R15
            s_d.cfgLoadPend = 1'b0;
        end

        // Capture address and data of a valid write while latching.
        // A later valid write simply overwrites the earlier one.
        if (s_q.latchEn && wrValid) begin
            s_d.latAddr  = busAddr;   // see R1 see R2
            s_d.latData  = busWrData; // see R2
            s_d.latValid = 1'b1;
        end

        // Reads. The configuration byte reloads the volatile copy, which is
        // the only way besides reset that new guard settings take hold.
        if (busRd) begin
            if (isNvAddr(busAddr)) begin
                s_d.rdData = nvStoredByte;
                s_d.cfg    = nvStoredByte; // see R14 see R15
            end else if (isArrayAddr(busAddr) && s_q.latchEn) begin
                // The array buses are held by the latch, so reads see it.
                s_d.rdData = s_q.latData; // see R6
            end else begin
                // Secured bytes read back like any other.
                s_d.rdData = arrayRdData; // see R20
            end
        end

        // Control register write.
        if (ctrlWr) begin
            if (s_q.latchEn && !s_q.latValid) begin
                // Latching has started but nothing valid is held yet.
                s_d.ctrlRef = 1'b1; // see R7
            end else begin
                // The mode may only move while voltage is off.
                if (!s_q.hv) begin
                    s_d.ersSel = wantErs; // see R9
                end
                // Voltage needs latching on and a valid write behind it.
                if (wantHv) begin
                    if (s_q.latchEn && s_q.latValid) begin
                        s_d.hv = 1'b1; // see R8
                    end else begin
                        s_d.ctrlRef = 1'b1; // see R8
                    end
                end else begin
                    s_d.hv = 1'b0; // see R10
                end
                // Latching only drops once voltage was already off, which
                // gives the array time to discharge before normal reads.
                if (wantLatch) begin
                    s_d.latchEn = 1'b1;
                end else if (s_q.hv) begin
                    s_d.latchEn = 1'b1; // see R11 see R24
                end else begin
                    s_d.latchEn  = 1'b0;
                    s_d.latValid = 1'b0;
                end
            end
        end

        // Once the secure bit reads as programmed it never disarms, and
        // since the byte can no longer be written its fields stay frozen.
        s_d.secure = s_q.secure || !s_d.cfg[eeprom_ctl_pkg::CFG_SECURE_BIT]; // see R22

        // The pump and the array voltage follow the enable bit unless the
        // target, its block or the secure option forbids the operation.
        s_d.pump  = s_d.hv && s_d.latValid && !guardBlk; // see R10 see R13 see R19
        s_d.opBlk = guardIdx; // see R3
    end

    // State register.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= S_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign rdData         = s_q.rdData;
    assign latchEnable    = s_q.latchEn;
    assign hvApply        = s_q.hv;
    assign eraseSelect    = s_q.ersSel;
    assign ctrlRefused    = s_q.ctrlRef;
    assign latchValid     = s_q.latValid;
    assign latchedAddr    = s_q.latAddr;
    assign latchedData    = s_q.latData;
    assign opBlock        = s_q.opBlk;
    assign pumpOn         = s_q.pump;
    assign volatileConfig = s_q.cfg;
    assign secureArmed    = s_q.secure;

endmodule // eeprom_erase_protect_control

// File: tb/eeprom_array_model.sv
`timescale 1ns/1ps
// Stands in for the array macro and the nonvolatile cell beside the control block.
module eeprom_array_model (
    // Clock and CPU read request.
    input  wire logic        sys_clk,
    input  wire logic [15:0] busAddr,
    input  wire logic        busRd,
    // Value the bench places in the nonvolatile cell.
    input  wire logic [7:0]  nvValue,
    // Contents returned to the control block.
    output logic [7:0]       arrayRdData,
    output logic [7:0]       nvStoredByte
);
    logic [7:0] noise = 8'h00; // Moves every cycle, so a stale sample never matches.

    // The noise pattern advances on every rising clock edge.
    always_ff @(posedge sys_clk) begin
        noise <= noise + 8'h3B;
    end

    // Stored bytes follow the address; outside a read the lines carry noise instead.
    assign arrayRdData  = busRd ? (busAddr[7:0] ^ 8'h5A) : noise;
    assign nvStoredByte = nvValue;
endmodule // eeprom_array_model

// File: tb/eeprom_epc_sva.sv
`timescale 1ns/1ps
// Watches the control block's ports for interlock and protection slips.
module eeprom_epc_sva (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [15:0] busAddr,
    input wire logic [7:0]  busWrData,
    input wire logic        busWr,
    input wire logic        busRd,
    input wire logic        ctrlWr,
    input wire logic [7:0]  ctrlWrData,
    input wire logic [7:0]  nvStoredByte,
    input wire logic [7:0]  rdData,
    input wire logic        latchEnable,
    input wire logic        hvApply,
    input wire logic [1:0]  eraseSelect,
    input wire logic        ctrlRefused,
    input wire logic        latchValid,
    input wire logic [15:0] latchedAddr,
    input wire logic [7:0]  latchedData,
    input wire logic [1:0]  opBlock,
    input wire logic        pumpOn,
    input wire logic [7:0]  volatileConfig,
    input wire logic        secureArmed
);
    // All checks share the one clock; reset silences them.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_ctrl_locked: assert property (ctrlWr && latchEnable && !latchValid |=> ctrlRefused && !hvApply
        && eraseSelect == $past(eraseSelect)) else $error("control write taken before a valid write");
    a_mode_frozen: assert property (ctrlWr && hvApply |=> eraseSelect == $past(eraseSelect))
        else $error("erase mode changed while voltage on");
    a_hv_clear_only: assert property (ctrlWr && hvApply && ctrlWrData[2:0] == 3'h0 |=> !hvApply && latchEnable)
        else $error("clearing both bits did not clear voltage only");
    a_hv_qualified: assert property ($rose(hvApply) |-> $past(latchEnable) && $past(latchValid))
        else $error("voltage enabled without latch and valid write");
    a_pump_guard: assert property (pumpOn |-> hvApply && !volatileConfig[opBlock])
        else $error("pump on for guarded block or without enable");
    a_pump_drop: assert property ($fell(hvApply) |-> !pumpOn) else $error("pump kept on");
    a_latch_take: assert property (busWr && !ctrlWr && latchEnable
        && busAddr inside {[16'h0800:16'h08EF], [16'h0900:16'h09FF]} |=> latchValid
        && latchedAddr == $past(busAddr) && latchedData == $past(busWrData) && opBlock == $past(busAddr[8:7]))
        else $error("valid write not latched");
    a_stray_ignored: assert property (busWr && !ctrlWr && !(busAddr inside {[16'h0800:16'h09FF], 16'hFE18})
        |=> $stable(latchedAddr) && $stable(latchedData)) else $error("stray write latched");
    a_secure_void: assert property (busWr && !ctrlWr && secureArmed && busAddr inside {[16'h08F0:16'h08FF]}
        |=> $stable(latchedAddr) && $stable(latchValid)) else $error("secured write counted as valid");
    a_latched_read: assert property (busRd && !busWr && latchEnable && busAddr inside {[16'h0800:16'h09FF]}
        |=> rdData == $past(latchedData)) else $error("latched read returned array data");
    a_cfg_reload: assert property (busRd && busAddr == 16'hFE18 |=> volatileConfig == $past(nvStoredByte)
        && rdData == $past(nvStoredByte)) else $error("config byte not copied on read");
    a_secure_sticky: assert property (secureArmed |=> secureArmed) else $error("secure option dropped");
    a_secure_modes: assert property (pumpOn && secureArmed |-> !eraseSelect[1]
        && !(latchedAddr inside {[16'h08F0:16'h08FF], 16'hFE18})) else $error("secure option not honoured");
    a_bulk_clean: assert property (pumpOn && eraseSelect == 2'b11 |-> volatileConfig[3:0] == 4'h0)
        else $error("bulk erase with a guarded block");
endmodule // eeprom_epc_sva

bind eeprom_erase_protect_control eeprom_epc_sva i_sva (.sys_clk, .rst, .busAddr, .busWrData, .busWr, .busRd,
    .ctrlWr, .ctrlWrData, .nvStoredByte, .rdData, .latchEnable, .hvApply, .eraseSelect, .ctrlRefused,
    .latchValid, .latchedAddr, .latchedData, .opBlock, .pumpOn, .volatileConfig, .secureArmed);

// File: tb/test_eeprom_erase_protect_control.sv
`timescale 1ns/1ps
// Self-checking bench: the CPU side is driven on falling edges, results are read one edge later.
module test_eeprom_erase_protect_control;
    logic        sys_clk, rst, busWr, busRd, ctrlWr;      // Clock, reset and strobes.
    logic [15:0] busAddr, latchedAddr;                    // Addresses.
    logic [7:0]  busWrData, ctrlWrData, nvValue, cfg;     // Stimulus and expected config.
    logic [7:0]  arrayRdData, nvStoredByte, rdData, latchedData, volatileConfig;
    logic        latchEnable, hvApply, ctrlRefused, latchValid, pumpOn, secureArmed;
    logic [1:0]  eraseSelect, opBlock;
    int          err_count, n_checks, cycles;             // Verdict and hang counters.

    eeprom_array_model i_mem (.sys_clk, .busAddr, .busRd, .nvValue, .arrayRdData, .nvStoredByte);
    eeprom_erase_protect_control i_dut (.sys_clk, .rst, .busAddr, .busWrData, .busWr, .busRd, .ctrlWr,
        .ctrlWrData, .arrayRdData, .nvStoredByte, .rdData, .latchEnable, .hvApply, .eraseSelect, .ctrlRefused,
        .latchValid, .latchedAddr, .latchedData, .opBlock, .pumpOn, .volatileConfig, .secureArmed);

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Prints the verdict and stops the run.
    task automatic conclude;
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Cuts a hang short; the whole run needs well under a thousand cycles.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end

    // Compares one observed value with its expectation.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // One-cycle strobes; each returns in the cycle after the taking edge.
    task automatic busW(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        busAddr = a;
        busWrData = d;
        busWr = 1'b1;
        @(negedge sys_clk);
        busWr = 1'b0;
    endtask
    task automatic busR(input logic [15:0] a);
        @(negedge sys_clk);
        busAddr = a;
        busRd = 1'b1;
        @(negedge sys_clk);
        busRd = 1'b0;
    endtask
    task automatic ctl(input logic [7:0] v);
        @(negedge sys_clk);
        ctrlWrData = v;
        ctrlWr = 1'b1;
        @(negedge sys_clk);
        ctrlWr = 1'b0;
    endtask

    // Expected pump state from mode, target and the copied configuration.
    function automatic logic expPump(input logic [1:0] m, input logic [15:0] a, input logic [7:0] c);
        return !c[a[8:7]] && !(m == 2'b11 && c[3:0] != 4'h0) && !(!c[4] && (m[1] || a inside {[16'h08F0:16'h08FF]}));
    endfunction

    // A full latch, write, voltage on, voltage off, unlatch sequence in mode m.
    task automatic op(input logic [1:0] m, input logic [15:0] a);
        logic [7:0] d;
        d = 8'($urandom);
        ctl({3'h0, m, 3'h4});
        busW(a, d);
        check(latchedAddr, a, "latched address");
        busR(a ^ 16'h0001);
        check(16'(rdData), 16'(d), "latched read");
        ctl({3'h0, m, 3'h5});
        check(16'(hvApply), 16'h0001, "voltage enable");
        check(16'(pumpOn), 16'(expPump(m, a, cfg)), "pump state");
        check(16'(opBlock), 16'(a[8:7]), "block index");
        ctl({3'h0, ~m, 3'h1});
        check(16'(eraseSelect), 16'(m), "mode lock");
        ctl(8'h00);
        check(16'(latchEnable), 16'h0001, "latch kept");
        check(16'(pumpOn), 16'h0000, "pump stopped");
        ctl(8'h00);
        check(16'(latchEnable), 16'h0000, "unlatched");
    endtask

    // Main sequence.
    initial begin
        {rst, busWr, busRd, ctrlWr} = 4'hF;
        {busWr, busRd, ctrlWr} = 3'h0;
        {busAddr, busWrData, ctrlWrData} = 32'h0000_0000;
        nvValue = 8'h10;
        cfg = 8'h10;
        void'($urandom(32'h6e07));
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(16'(volatileConfig), 16'h0010, "config copied at reset");
        // Refusals while latching with nothing latched.
        ctl(8'h14);
        busW(16'h1234, 8'hAA);
        check(16'(latchValid), 16'h0000, "stray write latched");
        ctl(8'h15);
        check(16'(ctrlRefused), 16'h0001, "early control write");
        check(16'(hvApply), 16'h0000, "early voltage");
        busW(16'h0850, 8'h11);
        ctl(8'h00);
        // Every mode at random unguarded targets.
        for (int m = 0; m < 4; m++) op(2'(m), 16'h0800 + 16'($urandom % 512));
        // New guards act only after the config byte is read.
        nvValue = 8'h12;
        @(negedge sys_clk);
        check(16'(volatileConfig), 16'h0010, "early guard change");
        busR(16'hFE18);
        check(16'(volatileConfig), 16'h0012, "guard reload");
        cfg = 8'h12;
        for (int b = 0; b < 4; b++) op(2'(b), 16'h0800 + 16'(b * 128) + 16'($urandom % 128));
        // Arm the secure option.
        nvValue = 8'h00;
        busR(16'hFE18);
        cfg = 8'h00;
        check(16'(secureArmed), 16'h0001, "secure armed");
        ctl(8'h0C);
        busW(16'h08F5, 8'h00);
        check(16'(latchValid), 16'h0000, "secured write");
        busW(16'hFE18, 8'hFF);
        check(16'(latchValid), 16'h0000, "config write when secure");
        busW(16'h0810, 8'h3C);
        ctl(8'h00);
        op(2'b01, 16'h0820);
        op(2'b10, 16'h0820);
        busR(16'h08F3);
        check(16'(rdData), 16'h00F3 ^ 16'h005A, "secured read");
        nvValue = 8'h1F;
        busR(16'hFE18);
        check(16'(secureArmed), 16'h0001, "secure sticky");
        conclude();
    end
endmodule // test_eeprom_erase_protect_control
